// File: hdl/wdts_top.sv
// Sleep-aware watchdog timer with APB register access and one interrupt.
// Assumes core control inputs come from logic on core_clk, so they are not
// synchronised; the APB master runs on the same clock.

`timescale 1ns/1ps
`default_nettype none

module wdts_top (
  input  wire logic                          core_clk,
  input  wire logic                          rstn,
  input  wire logic [wdts_pkg::ADDR_W-1:0]   paddr,
  input  wire logic                          psel,
  input  wire logic                          penable,
  input  wire logic                          pwrite,
  input  wire logic [31:0]                   pwdata,
  output var  logic [31:0]                   prdata,
  output var  logic                          pready,
  output var  logic                          pslverr,
  input  wire logic [1:0]                    watchdog_mode_config,
  input  wire logic                          core_reset,
  input  wire logic                          clear_watchdog_instruction,
  input  wire logic                          sleep_mode,
  input  wire logic                          osc_fail,
  input  wire logic                          ost_running,
  output var  logic                          device_reset_req,
  output var  logic                          wake_req,
  output var  logic                          irq,
  output var  logic                          watchdog_active
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [31:0]                       prdata_q,  prdata_d;
  logic                              pready_q,  pready_d;
  logic                              pslverr_q, pslverr_d;
  logic                              wr_en;
  logic                              addr_ok;

  logic                              swen_q,    swen_d;
  logic [wdts_pkg::PS_W-1:0]         ps_q,      ps_d;
  logic [wdts_pkg::STAT_W-1:0]       stat_q,    stat_d;
  logic [wdts_pkg::STAT_W-1:0]       mask_q,    mask_d;
  logic                              irq_q,     irq_d;
  logic [wdts_pkg::STAT_W-1:0]       stat_set;

  logic [wdts_pkg::OSC_DIV_W-1:0]    osc_cnt_q, osc_cnt_d;
  logic [wdts_pkg::BASE_W-1:0]       base_cnt_q, base_cnt_d;
  logic [wdts_pkg::CNT_W-1:0]        ms_cnt_q,  ms_cnt_d;
  logic                              sleep_q,   sleep_d;
  logic                              active_q,  active_d;
  logic                              rst_req_q, rst_req_d;
  logic                              wake_q,    wake_d;
  logic                              active;
  logic                              wdt_clear;
  logic                              osc_tick;
  logic                              base_tick;
  logic                              expire;
  logic [wdts_pkg::PS_W-1:0]         ps_eff;
  logic [wdts_pkg::CNT_W-1:0]        limit;
  wdts_pkg::wdts_mode_type           mode;

  localparam logic [wdts_pkg::OSC_DIV_W-1:0] OSC_LAST =
    wdts_pkg::OSC_DIV_W'(wdts_pkg::OSC_DIV - 1);
  localparam logic [wdts_pkg::BASE_W-1:0] BASE_LAST =
    wdts_pkg::BASE_W'(wdts_pkg::BASE_TICKS - 1);
  localparam logic [wdts_pkg::PS_W-1:0] PS_TOP = wdts_pkg::PS_W'(wdts_pkg::PS_MAX);
  localparam logic [wdts_pkg::OSC_DIV_W-1:0] OSC_DIV_ONE = wdts_pkg::OSC_DIV_W'(1);
  localparam logic [wdts_pkg::BASE_W-1:0]    BASE_ONE    = wdts_pkg::BASE_W'(1);
  localparam logic [wdts_pkg::CNT_W-1:0]     CNT_ONE     = wdts_pkg::CNT_W'(1);

  // ****************************************************************
  // APB slave
  // ****************************************************************

  // Decode and write strobe; a transfer completes on the second access cycle
  assign addr_ok = (paddr == wdts_pkg::ADDR_CTRL)   || (paddr == wdts_pkg::ADDR_STATUS) ||
                   (paddr == wdts_pkg::ADDR_MASK)   || (paddr == wdts_pkg::ADDR_STATE);
  assign wr_en   = psel && penable && pwrite && pready_q && addr_ok;

  // Next answer: ready one cycle into the access phase, read data captured then
  always_comb begin
    pready_d  = psel && penable && !pready_q;
    pslverr_d = 1'b0;
    prdata_d  = prdata_q;
    if (pready_d) begin
      pslverr_d = !addr_ok;
      prdata_d  = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          wdts_pkg::ADDR_CTRL: begin
            prdata_d[wdts_pkg::CTRL_EN_BIT] = swen_q;
            prdata_d[wdts_pkg::CTRL_PS_LSB +: wdts_pkg::PS_W] = ps_q;
          end
          wdts_pkg::ADDR_STATUS: begin
            prdata_d[wdts_pkg::STAT_W-1:0] = stat_q;
          end
          wdts_pkg::ADDR_MASK: begin
            prdata_d[wdts_pkg::STAT_W-1:0] = mask_q;
          end
          wdts_pkg::ADDR_STATE: begin
            prdata_d[wdts_pkg::CNT_W-1:0]       = ms_cnt_q;
            prdata_d[wdts_pkg::STATE_ACT_BIT]   = active_q;
          end
          default: begin
            prdata_d = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // Bus answer registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata_q  <= 32'h0000_0000;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ****************************************************************
  // Control, status and mask registers
  // ****************************************************************

  // Events that set sticky status bits
  always_comb begin
    stat_set = '0;
    stat_set[wdts_pkg::STAT_TO_BIT] = expire;
    stat_set[wdts_pkg::STAT_PD_BIT] = expire && sleep_mode;
  end

  // Register next values; status clears by writing one, a new event wins
  always_comb begin
    swen_d = swen_q;
    ps_d   = ps_q;
    mask_d = mask_q;
    stat_d = stat_q;
    if (wr_en && (paddr == wdts_pkg::ADDR_CTRL)) begin
      swen_d = pwdata[wdts_pkg::CTRL_EN_BIT];
      ps_d   = pwdata[wdts_pkg::CTRL_PS_LSB +: wdts_pkg::PS_W];
    end
    if (wr_en && (paddr == wdts_pkg::ADDR_MASK)) begin
      mask_d = pwdata[wdts_pkg::STAT_W-1:0];
    end
    if (wr_en && (paddr == wdts_pkg::ADDR_STATUS)) begin
      stat_d = stat_q & ~pwdata[wdts_pkg::STAT_W-1:0];
    end
    stat_d = stat_d | stat_set;
    if (core_reset) begin
      ps_d   = wdts_pkg::PS_RESET;
      swen_d = 1'b0;
    end
    irq_d = |(stat_d & mask_d);
  end

  // Register storage; status survives a core reset so the cause stays visible
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      swen_q <= 1'b0;
      ps_q   <= wdts_pkg::PS_RESET;
      mask_q <= '0;
      stat_q <= '0;
      irq_q  <= 1'b0;
    end else begin
      swen_q <= swen_d;
      ps_q   <= ps_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      irq_q  <= irq_d;
    end
  end

  // ****************************************************************
  // Watchdog timer
  // ****************************************************************

  // Mode decode: whether the watchdog runs in the present state
  always_comb begin
    mode = wdts_pkg::wdts_mode_type'(watchdog_mode_config);
    unique case (mode)
      wdts_pkg::WDTS_MODE_ON:    active = 1'b1;
      wdts_pkg::WDTS_MODE_AWAKE: active = !sleep_mode;
      wdts_pkg::WDTS_MODE_SW:    active = swen_q;
      wdts_pkg::WDTS_MODE_OFF:   active = 1'b0;
    endcase
  end

  // Period limit; reserved selections above the top code saturate at 2^18 ms (about 262 s)
  assign ps_eff = (ps_q > PS_TOP) ? PS_TOP : ps_q;
  assign limit  = (wdts_pkg::CNT_W'(1) << ps_eff) - wdts_pkg::CNT_W'(1);

  // Clearing conditions; both edges of the sleep state and ost_running clear the chain below
  assign wdt_clear = core_reset || clear_watchdog_instruction || osc_fail ||
                     !active;
  assign osc_tick  = (osc_cnt_q == OSC_LAST);
  assign base_tick = osc_tick && (base_cnt_q == BASE_LAST);

  // Counter chain: core clock to 31 kHz, to 1 ms, to the period
  always_comb begin
    sleep_d    = sleep_mode;
    active_d   = active;
    osc_cnt_d  = osc_cnt_q;
    base_cnt_d = base_cnt_q;
    ms_cnt_d   = ms_cnt_q;
    expire     = 1'b0;
    rst_req_d  = 1'b0;
    wake_d     = 1'b0;
    if (wdt_clear || (sleep_mode != sleep_q) || ost_running) begin
      osc_cnt_d  = '0;
      base_cnt_d = '0;
      ms_cnt_d   = '0;
    end else begin
      osc_cnt_d = osc_tick ? '0 : osc_cnt_q + OSC_DIV_ONE;
      if (osc_tick) begin
        base_cnt_d = (base_cnt_q == BASE_LAST) ? '0 : base_cnt_q + BASE_ONE;
      end
      if (base_tick) begin
        if (ms_cnt_q == limit) begin
          expire   = 1'b1;
          ms_cnt_d = '0;
        end else begin
          ms_cnt_d = ms_cnt_q + CNT_ONE;
        end
      end
    end
    if (expire) begin
      wake_d    = sleep_mode;
      rst_req_d = !sleep_mode;
    end
  end

  // Timer state and one-cycle request pulses
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      sleep_q    <= 1'b0;
      active_q   <= 1'b0;
      osc_cnt_q  <= '0;
      base_cnt_q <= '0;
      ms_cnt_q   <= '0;
      rst_req_q  <= 1'b0;
      wake_q     <= 1'b0;
    end else begin
      sleep_q    <= sleep_d;
      active_q   <= active_d;
      osc_cnt_q  <= osc_cnt_d;
      base_cnt_q <= base_cnt_d;
      ms_cnt_q   <= ms_cnt_d;
      rst_req_q  <= rst_req_d;
      wake_q     <= wake_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************

  // All outputs straight from flip-flops
  assign prdata           = prdata_q;
  assign pready           = pready_q;
  assign pslverr          = pslverr_q;
  assign device_reset_req = rst_req_q;
  assign wake_req         = wake_q;
  assign irq              = irq_q;
  assign watchdog_active  = active_q;

endmodule // wdts_top

`default_nettype wire

// File: hdl/wdts_pkg.sv
// Constants, register map and mode encoding for the sleep-aware watchdog.
// Assumes a single 40 MHz core clock and an APB master on the same clock.

package wdts_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned OSC_HZ       = 31_000;
  localparam int unsigned BASE_US      = 1_000;
  localparam int unsigned OSC_DIV      = CLK_HZ / OSC_HZ;
  localparam int unsigned BASE_TICKS   = (OSC_HZ * BASE_US) / 1_000_000;
  localparam int unsigned OSC_DIV_W    = 11;
  localparam int unsigned BASE_W       = 5;

  // ****************************************************************
  // Period selection
  // ****************************************************************
  localparam int unsigned PS_W         = 5;
  localparam int unsigned PS_MAX       = 18;
  localparam int unsigned CNT_W        = 19;
  localparam logic [4:0]  PS_RESET     = 5'h0b;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam int unsigned ADDR_W       = 12;
  localparam logic [11:0] ADDR_CTRL    = 12'h000;
  localparam logic [11:0] ADDR_STATUS  = 12'h004;
  localparam logic [11:0] ADDR_MASK    = 12'h008;
  localparam logic [11:0] ADDR_STATE   = 12'h00c;
  localparam int unsigned CTRL_EN_BIT  = 0;
  localparam int unsigned CTRL_PS_LSB  = 1;
  localparam int unsigned STAT_TO_BIT  = 0;
  localparam int unsigned STAT_PD_BIT  = 1;
  localparam int unsigned STAT_W       = 2;
  localparam int unsigned STATE_ACT_BIT = 24;

  // ****************************************************************
  // Watchdog mode configuration
  // ****************************************************************
  typedef enum logic [1:0] {
    WDTS_MODE_OFF   = 2'b00,
    WDTS_MODE_SW    = 2'b01,
    WDTS_MODE_AWAKE = 2'b10,
    WDTS_MODE_ON    = 2'b11
  } wdts_mode_type;

endpackage

// File: testbench/wdts_asserts.sv
// Port checker for the sleep-aware watchdog.
// Assumes binding to wdts_top, one core_clk domain, rstn low active.
`timescale 1ns/1ps
`default_nettype none
module wdts_asserts (
  input wire logic       core_clk,
  input wire logic       rstn,
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic [1:0] watchdog_mode_config,
  input wire logic       core_reset,
  input wire logic       clear_watchdog_instruction,
  input wire logic       sleep_mode,
  input wire logic       osc_fail,
  input wire logic       ost_running,
  input wire logic       device_reset_req,
  input wire logic       wake_req,
  input wire logic       watchdog_active
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  // Clear causes other than inactivity and sleep changes, and any expiry pulse
  wire logic clr = core_reset | clear_watchdog_instruction | osc_fail | ost_running;
  wire logic expd = device_reset_req | wake_req;
  sequence s_wait; psel && penable && !pready; endsequence
  sequence s_ans; pready; endsequence
  AST_APB_ONE_WAIT: assert property (s_wait |=> s_ans)
    else $error("bus answer late");
  AST_RESET_AWAKE: assert property (device_reset_req |-> !$past(sleep_mode))
    else $error("reset request while asleep");
  AST_WAKE_ASLEEP: assert property (wake_req |-> $past(sleep_mode))
    else $error("wake request while awake");
  AST_OFF_NO_EXPIRY: assert property (expd |-> $past(watchdog_mode_config) != 2'b00)
    else $error("expiry while off");
  AST_ON_ACTIVE: assert property ($past(rstn) && $past(watchdog_mode_config) == 2'b11 |-> watchdog_active)
    else $error("always-on mode inactive");
  AST_OFF_INACTIVE: assert property ($past(rstn) && $past(watchdog_mode_config) == 2'b00 |-> !watchdog_active)
    else $error("off mode active");
  AST_AWAKE_SLEEP_OFF: assert property ($past(rstn) && $past(watchdog_mode_config) == 2'b10 && $past(sleep_mode) |-> !watchdog_active)
    else $error("awake-only mode active in sleep");
  AST_CLEAR_HOLDS: assert property ($past(clr) && $past(clr, 2) |-> !expd)
    else $error("expiry while cleared");
  AST_SLEEP_EDGE: assert property ($past(sleep_mode) != $past(sleep_mode, 2) |-> !expd)
    else $error("expiry at sleep change");
  AST_REQ_PULSE: assert property (expd |=> !expd)
    else $error("expiry pulse too long");
endmodule // wdts_asserts
bind wdts_top wdts_asserts i_chk (.core_clk, .rstn, .psel, .penable, .pready,
  .watchdog_mode_config, .core_reset, .clear_watchdog_instruction, .sleep_mode,
  .osc_fail, .ost_running, .device_reset_req, .wake_req, .watchdog_active);
`default_nettype wire

// File: testbench/wdts_bench.sv
// Self-checking bench for the sleep-aware watchdog.
// Assumes wdts_top at 40 MHz with the checker bound in its own file.
`timescale 1ns/1ps
`default_nettype none
module wdts_bench;
  logic        core_clk, rstn, psel, penable, pwrite, core_reset, sleep_mode;
  logic        clear_watchdog_instruction, osc_fail, ost_running;
  logic        pready, pslverr, device_reset_req, wake_req, irq, watchdog_active;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [1:0]  watchdog_mode_config;
  int          fails = 0;
  int          n_checks = 0;
  wdts_top i_dut (.core_clk, .rstn, .paddr, .psel, .penable, .pwrite, .pwdata,
    .prdata, .pready, .pslverr, .watchdog_mode_config, .core_reset,
    .clear_watchdog_instruction, .sleep_mode, .osc_fail, .ost_running,
    .device_reset_req, .wake_req, .irq, .watchdog_active);
  // ************************************************************
  // Helpers
  // ************************************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    chk(32'(k < 50), 32'h1, "bus answer");
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input logic [11:0] a, input logic [31:0] x, input string m);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(r, x, m);
  endtask
  task automatic mode_chk(input logic [1:0] m, input logic en, input logic s, input logic x);
    wr(wdts_pkg::ADDR_CTRL, {31'h0, en});
    watchdog_mode_config <= m;
    sleep_mode <= s;
    cyc(3);
    chk({31'h0, watchdog_active}, {31'h0, x}, "active state");
  endtask
  // Counts cycles to the chosen expiry pulse and checks the span
  task automatic wait_req(input logic slp, input int lo, input int hi);
    int n;
    n = 0;
    while (n < 42000 && (slp ? wake_req : device_reset_req) !== 1'b1) begin
      @(posedge core_clk);
      n++;
    end
    chk(32'(n >= lo && n <= hi), 32'h1, "expiry time");
  endtask
  // ************************************************************
  // Scenarios
  // ************************************************************
  task automatic t_regs();
    logic [31:0] r;
    logic        e;
    rd_chk(wdts_pkg::ADDR_CTRL, 32'h16, "ctrl reset");
    apb(1'b0, 12'h010, 32'h0, r, e);
    chk({31'h0, e}, 32'h1, "unmapped error");
    wr(wdts_pkg::ADDR_MASK, 32'h3);
    $display("t_regs done");
  endtask
  task automatic t_modes();
    mode_chk(2'b01, 1'b1, 1'b0, 1'b1);
    mode_chk(2'b01, 1'b1, 1'b1, 1'b1);
    mode_chk(2'b01, 1'b0, 1'b1, 1'b0);
    mode_chk(2'b10, 1'b0, 1'b0, 1'b1);
    mode_chk(2'b10, 1'b0, 1'b1, 1'b0);
    mode_chk(2'b11, 1'b0, 1'b1, 1'b1);
    mode_chk(2'b00, 1'b1, 1'b0, 1'b0);
    $display("t_modes done");
  endtask
  task automatic t_expire();
    mode_chk(2'b11, 1'b0, 1'b0, 1'b1);
    cyc(1000);
    clear_watchdog_instruction <= 1'b1;
    cyc(1);
    clear_watchdog_instruction <= 1'b0;
    cyc(1000);
    ost_running <= 1'b1;
    osc_fail <= 1'b1;
    cyc(3);
    osc_fail <= 1'b0;
    cyc(7);
    ost_running <= 1'b0;
    wait_req(1'b0, 39988, 39993);
    cyc(2);
    chk({31'h0, irq}, 32'h1, "irq raised");
    rd_chk(wdts_pkg::ADDR_STATUS, 32'h1, "awake status");
    wr(wdts_pkg::ADDR_STATUS, 32'h3);
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    $display("t_expire done");
  endtask
  task automatic t_sleep();
    wr(wdts_pkg::ADDR_MASK, 32'h0);
    cyc(1000);
    sleep_mode <= 1'b1;
    wait_req(1'b1, 39988, 39994);
    sleep_mode <= 1'b0;
    cyc(2);
    chk({31'h0, irq}, 32'h0, "irq masked");
    rd_chk(wdts_pkg::ADDR_STATUS, 32'h3, "sleep status");
    wr(wdts_pkg::ADDR_MASK, 32'h3);
    cyc(2);
    chk({31'h0, irq}, 32'h1, "irq unmasked");
    core_reset <= 1'b1;
    cyc(1);
    core_reset <= 1'b0;
    rd_chk(wdts_pkg::ADDR_CTRL, 32'h16, "ctrl after reset");
    $display("t_sleep done");
  endtask
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // ************************************************************
  // Clock, watchdog and main sequence
  // ************************************************************
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    #(95000 * 25);
    fails++;
    $display("Error %0t: run timed out", $time);
    end_of_test();
  end
  initial begin
    {psel, penable, pwrite, core_reset, sleep_mode} = '0;
    {clear_watchdog_instruction, osc_fail, ost_running} = '0;
    paddr = '0;
    pwdata = '0;
    watchdog_mode_config = 2'b00;
    rstn = 1'b0;
    cyc(6);
    rstn <= 1'b1;
    cyc(1);
    t_regs();
    t_modes();
    t_expire();
    t_sleep();
    end_of_test();
  end
endmodule // wdts_bench
`default_nettype wire
